// [rtl/pcc_config_regs.sv]
`timescale 1ns/1ns
// Summary of operation
// - Command bit 8 must be set before the device may drive the system-error pin.
// - Command bit 5 turns on the palette snoop behaviour, otherwise palette accesses are ordinary.
// - Command bit 4 allows memory write and invalidate as master, otherwise plain memory write is used.
// - Command bit 2 must be set before the device starts any bus transaction of its own.
// - Command bit 1 makes the device claim memory cycles to its 16MByte windows and the VGA memory range.
// - The VGA memory range claimed follows the graphics miscellaneous map select bits 3:2 and the VGA enable.
// - Command bit 0 makes the device claim I/O at 0x3B0-0x3BB, 0x3C0-0x3DF and their aliases.
// - The class code is read-only and returns 0x030000 for a VGA compatible controller.
// - Base class, sub-class and interface bytes sit at 0x0B, 0x0A and 0x09 and each reads alone.
// - Byte 0x08 returns a read-only vendor chosen revision identifier.
// - Each assertion of the system-error pin sets status bit 30, and only while bit 8 allows driving.
module pcc_config_regs
  import pcc_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5A, // arbitrary value
  parameter int         IDX_W    = 6
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // configuration access port
  input  wire logic        cfgValid,
  input  wire logic        cfgWrite,
  input  wire logic [5:0]  cfgIndex,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output logic      [31:0] cfgRdData,
  output logic             cfgRdValid,
  // target decode
  input  wire logic        accValid,
  input  wire logic        accIsMem,
  input  wire logic [31:0] accAddr,
  input  wire logic [1:0]  vgaMemMap,
  input  wire logic        vgaEnable,
  input  wire logic [7:0]  window0Base,
  input  wire logic [7:0]  window1Base,
  output logic             memClaim,
  output logic             ioClaim,
  // master side
  input  wire logic        mstReq,
  input  wire logic        mstWantInval,
  output logic             mstGo,
  output logic             mstInval,
  output logic             paletteSnoop,
  // system error pin
  input  wire logic        errEvent,
  output logic             serrOut,
  output logic             serrOe
);
  // the index port is fixed at six bits, so no other width can be served
  if (IDX_W != 6) begin : g_idx_check
    $error("IDX_W must be 6");
  end

  pcc_dec_if decBus ();

  logic [15:0] pciCommand;
  logic        systemErrorRaised;
  logic [15:0] next_pciCommand;
  logic        next_systemErrorRaised;
  logic [31:0] next_cfgRdData;
  logic        next_cfgRdValid;
  logic        next_mstGo;
  logic        next_mstInval;
  logic        next_paletteSnoop;
  logic        next_serrOe;
  logic [15:0] wrBits;
  logic [15:0] laneMask;
  logic        cmdHit;
  logic        system_error_driver_enable;
  logic        line_write_cmd_enable;

  assign system_error_driver_enable = pciCommand[CMD_SERR_EN];
  assign line_write_cmd_enable      = pciCommand[CMD_LINE_WRITE];
  assign cmdHit = cfgValid && cfgWrite && (cfgIndex == IDX_CMD_STATUS);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    laneMask = {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};
    wrBits   = cfgWrData[15:0] & laneMask & CMD_WR_MASK;
    next_pciCommand = pciCommand;
    if (cmdHit) begin
      next_pciCommand = (pciCommand & ~(laneMask & CMD_WR_MASK)) | wrBits;
    end
    // hardware set beats a write-one clear in the same cycle
    next_systemErrorRaised = systemErrorRaised;
    if (cmdHit && cfgByteEn[3] && cfgWrData[16 + STS_SERR_BIT]) begin
      next_systemErrorRaised = 1'b0;
    end
    next_serrOe = errEvent && system_error_driver_enable;
    if (next_serrOe) begin
      next_systemErrorRaised = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cfgRdValid = cfgValid && !cfgWrite;
    next_cfgRdData  = 32'h0000_0000;
    if (cfgValid && !cfgWrite) begin
      unique case (cfgIndex)
        IDX_CMD_STATUS: begin
          next_cfgRdData[15:0]                = pciCommand;
          next_cfgRdData[16 + STS_SERR_BIT]   = systemErrorRaised;
        end
        IDX_CLASS_REV: begin
          next_cfgRdData = {CLASS_VGA, REVISION};
        end
        default: next_cfgRdData = 32'h0000_0000;
      endcase
      // every byte lane answers alone, disabled lanes read zero
      for (int b = 0; b < 4; b++) begin
        if (!cfgByteEn[b]) next_cfgRdData[b*8 +: 8] = 8'h00;
      end
    end
    next_mstGo        = mstReq && pciCommand[CMD_BUS_MASTER];
    next_mstInval     = next_mstGo && mstWantInval && line_write_cmd_enable;
    next_paletteSnoop = pciCommand[CMD_PAL_SNOOP];
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pciCommand        <= CMD_RESET;
      systemErrorRaised <= 1'b0;
      cfgRdData         <= 32'h0000_0000;
      cfgRdValid        <= 1'b0;
      mstGo             <= 1'b0;
      mstInval          <= 1'b0;
      paletteSnoop      <= 1'b0;
      serrOe            <= 1'b0;
      serrOut           <= 1'b0;
    end else begin
      pciCommand        <= next_pciCommand;
      systemErrorRaised <= next_systemErrorRaised;
      cfgRdData         <= next_cfgRdData;
      cfgRdValid        <= next_cfgRdValid;
      mstGo             <= next_mstGo;
      mstInval          <= next_mstInval;
      paletteSnoop      <= next_paletteSnoop;
      serrOe            <= next_serrOe;
      // open-drain pin only ever pulls low
      serrOut           <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign decBus.memEnable   = pciCommand[CMD_MEM_SPACE];
  assign decBus.ioEnable    = pciCommand[CMD_IO_SPACE];
  assign decBus.vgaEnable   = vgaEnable;
  assign decBus.vgaMemMap   = vgaMemMap;
  assign decBus.window0Base = window0Base;
  assign decBus.window1Base = window1Base;
  assign decBus.accValid    = accValid;
  assign decBus.accIsMem    = accIsMem;
  assign decBus.accAddr     = accAddr;
  assign memClaim           = decBus.memClaim;
  assign ioClaim            = decBus.ioClaim;

  pcc_vga_decode u_decode (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .dec      (decBus)
  );

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_serr_driver_gate: assert property (serrOe |-> $past(system_error_driver_enable))
    else $error("system error driven while disabled");
  a_snoop_follow: assert property (paletteSnoop == $past(pciCommand[CMD_PAL_SNOOP]))
    else $error("palette snoop does not follow command");
  a_inval_gate: assert property (mstInval |-> mstGo && $past(line_write_cmd_enable))
    else $error("invalidate write while not enabled");
  a_master_gate: assert property ($rose(mstGo) |-> $past(pciCommand[CMD_BUS_MASTER]) && $past(mstReq))
    else $error("master start without bus master enable");
  a_mem_claim_gate: assert property (memClaim |-> $past(pciCommand[CMD_MEM_SPACE]) && $past(accIsMem))
    else $error("memory claim while memory decode off");
  a_vga_map_range: assert property ((accValid && accIsMem && pciCommand[CMD_MEM_SPACE] && vgaEnable
      && vgaMemMap == MAP_B8_32K && accAddr == VGA_B8000) |=> memClaim)
    else $error("vga range not claimed");
  a_io_claim_range: assert property ((accValid && !accIsMem && pciCommand[CMD_IO_SPACE]
      && accAddr[9:0] == IO_COLOR_HI) |=> ioClaim)
    else $error("vga io port not claimed");
  a_class_read: assert property ((cfgValid && !cfgWrite && cfgIndex == IDX_CLASS_REV && cfgByteEn[3])
      |=> cfgRdValid && cfgRdData[31:24] == CLASS_VGA[23:16])
    else $error("class code base byte wrong");
  a_class_bytes: assert property ((cfgValid && !cfgWrite && cfgIndex == IDX_CLASS_REV && cfgByteEn == 4'h2)
      |=> cfgRdData == {16'h0000, CLASS_VGA[7:0], 8'h00})
    else $error("single class byte read wrong");
  a_rev_read: assert property ((cfgValid && !cfgWrite && cfgIndex == IDX_CLASS_REV && cfgByteEn[0])
      |=> cfgRdData[7:0] == REVISION)
    else $error("revision byte wrong");
  a_reserved_zero: assert property ((pciCommand & ~CMD_WR_MASK) == 16'h0000)
    else $error("reserved command bit set");
  a_status_set: assert property (serrOe |-> systemErrorRaised ##1 $past(errEvent, 2))
    else $error("status not set on system error");
  a_serr_follow: assert property ((errEvent && system_error_driver_enable) |=> serrOe)
    else $error("system error not driven while enabled");
  a_inval_off: assert property (!line_write_cmd_enable |=> !mstInval)
    else $error("invalidate write with line write disabled");
  a_master_follow: assert property ((mstReq && pciCommand[CMD_BUS_MASTER]) |=> mstGo)
    else $error("master request not granted while enabled");
  a_mem_off_quiet: assert property (!pciCommand[CMD_MEM_SPACE] |=> !memClaim)
    else $error("memory claim with memory decode off");
  a_io_claim_gate: assert property (ioClaim |-> $past(pciCommand[CMD_IO_SPACE]) && !$past(accIsMem))
    else $error("io claim while io decode off");
  a_read_answer: assert property ((cfgValid && !cfgWrite) |=> cfgRdValid)
    else $error("read request not answered");
  a_lane_zero: assert property ((cfgValid && !cfgWrite && !cfgByteEn[3]) |=> cfgRdData[31:24] == 8'h00)
    else $error("disabled read lane not zero");
  a_class_mid: assert property ((cfgValid && !cfgWrite && cfgIndex == IDX_CLASS_REV && cfgByteEn == 4'h4)
      |=> cfgRdData == {8'h00, CLASS_VGA[15:8], 16'h0000})
    else $error("sub-class byte read wrong");
  a_cmd_lane_write: assert property ((cmdHit && cfgByteEn[0])
      |=> pciCommand[7:0] == ($past(cfgWrData[7:0]) & CMD_WR_MASK[7:0]))
    else $error("command low byte write lost");
  a_status_needs_serr: assert property ($rose(systemErrorRaised) |-> serrOe)
    else $error("status flag set without system error");
endmodule : pcc_config_regs

// [rtl/pcc_pkg.sv]
package pcc_pkg;
  // configuration dword indices (byte offset / 4)
  localparam logic [5:0]  IDX_CMD_STATUS  = 6'h01;
  localparam logic [5:0]  IDX_CLASS_REV   = 6'h02;
  // command bit positions
  localparam int          CMD_IO_SPACE    = 0;
  localparam int          CMD_MEM_SPACE   = 1;
  localparam int          CMD_BUS_MASTER  = 2;
  localparam int          CMD_LINE_WRITE  = 4;
  localparam int          CMD_PAL_SNOOP   = 5;
  localparam int          CMD_SERR_EN     = 8;
  localparam logic [15:0] CMD_WR_MASK     = 16'h0137;
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  // status bit position within the upper half of the dword
  localparam int          STS_SERR_BIT    = 14;
  localparam logic [23:0] CLASS_VGA       = 24'h03_0000;
  // vga decode constants
  localparam logic [9:0]  IO_MONO_LO      = 10'h3B0;
  localparam logic [9:0]  IO_MONO_HI      = 10'h3BB;
  localparam logic [9:0]  IO_COLOR_LO     = 10'h3C0;
  localparam logic [9:0]  IO_COLOR_HI     = 10'h3DF;
  localparam logic [1:0]  MAP_A0_128K     = 2'h0;
  localparam logic [1:0]  MAP_A0_64K      = 2'h1;
  localparam logic [1:0]  MAP_B0_32K      = 2'h2;
  localparam logic [1:0]  MAP_B8_32K      = 2'h3;
  localparam logic [31:0] VGA_A0000       = 32'h000A_0000;
  localparam logic [31:0] VGA_B0000       = 32'h000B_0000;
  localparam logic [31:0] VGA_B8000       = 32'h000B_8000;
  localparam logic [31:0] VGA_C0000       = 32'h000C_0000;
endpackage : pcc_pkg

// [rtl/pcc_dec_if.sv]
`timescale 1ns/1ns
interface pcc_dec_if;
  logic        memEnable;
  logic        ioEnable;
  logic        vgaEnable;
  logic [1:0]  vgaMemMap;
  logic [7:0]  window0Base;
  logic [7:0]  window1Base;
  logic        accValid;
  logic        accIsMem;
  logic [31:0] accAddr;
  logic        memClaim;
  logic        ioClaim;
  modport regs (output memEnable, ioEnable, vgaEnable, vgaMemMap, window0Base, window1Base,
                output accValid, accIsMem, accAddr, input memClaim, ioClaim);
  modport dec  (input memEnable, ioEnable, vgaEnable, vgaMemMap, window0Base, window1Base,
                input accValid, accIsMem, accAddr, output memClaim, ioClaim);
endinterface : pcc_dec_if

// [rtl/pcc_vga_decode.sv]
`timescale 1ns/1ns
module pcc_vga_decode
  import pcc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // decode request and result
  pcc_dec_if.dec    dec
);
  logic       inVga;
  logic       inWin;
  logic       ioHit;
  logic [9:0] ioAddr;
  logic       next_memClaim;
  logic       next_ioClaim;
  logic       memClaim;
  logic       ioClaim;

  always_comb begin
    ioAddr = dec.accAddr[9:0];
    // only ten address bits are compared so every alias decodes too
    ioHit = ((ioAddr >= IO_MONO_LO) && (ioAddr <= IO_MONO_HI)) ||
            ((ioAddr >= IO_COLOR_LO) && (ioAddr <= IO_COLOR_HI));
    unique case (dec.vgaMemMap)
      MAP_A0_128K: inVga = (dec.accAddr >= VGA_A0000) && (dec.accAddr < VGA_C0000);
      MAP_A0_64K:  inVga = (dec.accAddr >= VGA_A0000) && (dec.accAddr < VGA_B0000);
      MAP_B0_32K:  inVga = (dec.accAddr >= VGA_B0000) && (dec.accAddr < VGA_B8000);
      MAP_B8_32K:  inVga = (dec.accAddr >= VGA_B8000) && (dec.accAddr < VGA_C0000);
    endcase
    inWin = (dec.accAddr[31:24] == dec.window0Base) || (dec.accAddr[31:24] == dec.window1Base);
    next_memClaim = dec.accValid && dec.accIsMem && dec.memEnable &&
                    (inWin || (inVga && dec.vgaEnable));
    next_ioClaim  = dec.accValid && !dec.accIsMem && dec.ioEnable && ioHit;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memClaim <= 1'b0;
      ioClaim  <= 1'b0;
    end else begin
      memClaim <= next_memClaim;
      ioClaim  <= next_ioClaim;
    end
  end

  assign dec.memClaim = memClaim;
  assign dec.ioClaim  = ioClaim;
endmodule : pcc_vga_decode

// [bench/pcc_host_model.sv]
`timescale 1ns/1ns
module pcc_host_model (
  // clock
  input  wire logic        core_clk,
  // configuration request
  output logic             cfgValid,
  output logic             cfgWrite,
  output logic      [5:0]  cfgIndex,
  output logic      [3:0]  cfgByteEn,
  output logic      [31:0] cfgWrData,
  // answer
  input  wire logic [31:0] cfgRdData,
  input  wire logic        cfgRdValid
);
  initial begin
    cfgValid  = 1'b0;
    cfgWrite  = 1'b0;
    cfgIndex  = 6'h00;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////////////////////
  // gap adds idle cycles, so the host can be prompt or slow
  task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] d, input int gap, output logic [31:0] rd);
    repeat (gap + 1) @(posedge core_clk);
    cfgValid  <= 1'b1;
    cfgWrite  <= wr;
    cfgIndex  <= idx;
    cfgByteEn <= be;
    cfgWrData <= d;
    @(posedge core_clk);
    cfgValid  <= 1'b0;
    // released lines must not keep showing the old request
    cfgWrData <= ~d;
    cfgIndex  <= ~idx;
    rd = 'x;
    if (!wr) begin
      @(posedge core_clk);
      if (cfgRdValid === 1'b1) rd = cfgRdData;
    end
  endtask : access
endmodule : pcc_host_model

// [bench/pci_config_command_class_rev_tb_top.sv]
`timescale 1ns/1ns
module pci_config_command_class_rev_tb_top;
  localparam logic [7:0] REV = 8'h5A; // arbitrary value
  logic core_clk, rst_n, cfgValid, cfgWrite, cfgRdValid, accValid, accIsMem, vgaEnable;
  logic memClaim, ioClaim, mstReq, mstWantInval, mstGo, mstInval, paletteSnoop;
  logic errEvent, serrOut, serrOe;
  logic [5:0]  cfgIndex;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData, accAddr, rd;
  logic [1:0]  vgaMemMap;
  logic [7:0]  window0Base, window1Base;
  logic [15:0] cmd;
  int          failures, n_compared, seed;
  pcc_host_model i_host (.core_clk(core_clk), .cfgValid(cfgValid), .cfgWrite(cfgWrite),
    .cfgIndex(cfgIndex), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));
  pcc_config_regs #(.REVISION(REV)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .cfgValid(cfgValid), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex), .cfgByteEn(cfgByteEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .accValid(accValid), .accIsMem(accIsMem), .accAddr(accAddr), .vgaMemMap(vgaMemMap),
    .vgaEnable(vgaEnable), .window0Base(window0Base), .window1Base(window1Base),
    .memClaim(memClaim), .ioClaim(ioClaim), .mstReq(mstReq), .mstWantInval(mstWantInval),
    .mstGo(mstGo), .mstInval(mstInval), .paletteSnoop(paletteSnoop),
    .errEvent(errEvent), .serrOut(serrOut), .serrOe(serrOe));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chkWord
  task automatic chkFlag(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : chkFlag
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // only exact for a window address (top byte 0x80 or 0x90) or 0x000B_8000; on I/O passes its result is masked by accIsMem
  function automatic logic expMem(input logic [15:0] c, input logic [1:0] m, input logic en,
                                  input logic [31:0] a);
    return c[1] & ((a[31:24] == 8'h80) | (a[31:24] == 8'h90) | (en & (m[0] == m[1])));
  endfunction : expMem
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    failures++;
    end_sim();
  end
  initial begin
    seed = 68;
    rst_n = 1'b0;
    {accValid, accIsMem, mstReq, mstWantInval, errEvent, vgaEnable} = '0;
    accAddr = 32'h0000_0000;
    vgaMemMap = 2'h0;
    window0Base = 8'h80;
    window1Base = 8'h90;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    i_host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd);
    chkWord("reset_cmd", 32'h0000_0000, rd);
    i_host.access(1'b0, 6'h02, 4'hF, 32'h0, 0, rd);
    chkWord("class_rev", {24'h03_0000, REV}, rd);
    i_host.access(1'b1, 6'h02, 4'hF, 32'hFFFF_FFFF, 0, rd);
    for (int b = 0; b < 4; b++) begin
      i_host.access(1'b0, 6'h02, 4'(1 << b), 32'h0, b, rd);
      chkWord("class_lane", {24'h03_0000, REV} & (32'h0000_00FF << (8 * b)), rd);
    end
    i_host.access(1'b0, 6'h3F, 4'hF, 32'h0, 0, rd);
    chkWord("unmapped", 32'h0000_0000, rd);
    $display("test identity done");
    for (int i = 0; i < 10; i++) begin
      // pass 3 forces memory decode and the b8000 map so the vga range is really claimed
      cmd = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (i == 3) ? (16'($random(seed)) | 16'h0002)
          : 16'($random(seed));
      // lane 3 clears the sticky error flag while the command is written
      i_host.access(1'b1, 6'h01, 4'hB, {16'h4000, cmd}, i % 3, rd);
      @(posedge core_clk);
      accValid <= 1'b1;
      accIsMem <= i[0];
      errEvent <= 1'b1;
      mstReq <= 1'b1;
      mstWantInval <= 1'b1;
      vgaMemMap <= (i == 3) ? 2'h3 : 2'($random(seed));
      vgaEnable <= (i == 3) ? 1'b1 : 1'($random(seed));
      accAddr <= !i[0] ? {22'($random(seed)), 10'h3DF}
               : (i % 4 == 1) ? {(i[2] ? 8'h80 : 8'h90), 24'h00_1234} : 32'h000B_8000;
      @(posedge core_clk);
      {accValid, errEvent, mstReq} <= 3'b000;
      #1;
      chkFlag("ioClaim", cmd[0] & ~accIsMem, ioClaim);
      chkFlag("memClaim", accIsMem & expMem(cmd, vgaMemMap, vgaEnable, accAddr), memClaim);
      chkFlag("mstGo", cmd[2], mstGo);
      chkFlag("mstInval", cmd[2] & cmd[4], mstInval);
      chkFlag("serrOe", cmd[8], serrOe);
      chkFlag("serrOut", 1'b0, serrOut);
      chkFlag("paletteSnoop", cmd[5], paletteSnoop);
      i_host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd);
      chkWord("cmd_status", {1'b0, cmd[8], 14'h0000, cmd & 16'h0137}, rd);
    end
    $display("test command done");
    // lane 1 alone: only bit 8 survives, and lane 3 is off so the flag is untouched
    i_host.access(1'b1, 6'h01, 4'hB, 32'h4000_0000, 0, rd);
    i_host.access(1'b1, 6'h01, 4'h2, 32'hFFFF_FFFF, 1, rd);
    i_host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd);
    chkWord("lane1_write", 32'h0000_0100, rd);
    // error event and a write-one clear in the same cycle: the set must win
    errEvent <= 1'b1;
    i_host.access(1'b1, 6'h01, 4'h8, 32'h4000_0000, 0, rd);
    errEvent <= 1'b0;
    i_host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd);
    chkWord("set_wins", 32'h4000_0100, rd);
    // mid-run reset lands on the edge that would raise mstGo and must clear command and flag
    i_host.access(1'b1, 6'h01, 4'h3, 32'h0000_0137, 0, rd);
    @(posedge core_clk);
    mstReq <= 1'b1;
    @(posedge core_clk);
    rst_n  <= 1'b0;
    mstReq <= 1'b0;
    #1;
    chkFlag("mstGo_in_reset", 1'b0, mstGo);
    chkFlag("snoop_in_reset", 1'b0, paletteSnoop);
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    i_host.access(1'b0, 6'h01, 4'hF, 32'h0, 0, rd);
    chkWord("cmd_after_reset", 32'h0000_0000, rd);
    $display("test corner done");
    end_sim();
  end
endmodule : pci_config_command_class_rev_tb_top
